// ### hw/asr_pkg.sv
package asr_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int LANES  = 2;
	localparam int CLK_PERIOD_NS = 20;
	// minimum times in ns
	localparam int T_RC_NS  = 15;
	localparam int T_DOE_NS = 7;
	localparam int T_AA_NS  = 15;
	localparam int T_WC_NS  = 15;
	localparam int T_PWE_NS = 10;
	localparam int T_SD_NS  = 8;
	localparam int T_HZ_NS  = 7;
	// least times round up, never below one cycle
	function automatic int asr_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int RD_CYC  = asr_cyc(T_AA_NS) + 1;
	localparam int WR_CYC  = asr_cyc(T_PWE_NS);
	localparam int WC_CYC  = asr_cyc(T_WC_NS);
	localparam int HZ_CYC  = asr_cyc(T_HZ_NS);
	localparam int CNT_W   = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
	typedef enum logic [2:0] {ASR_IDLE, ASR_RD, ASR_WR, ASR_WHOLD, ASR_TURN} asr_state_t;
endpackage

// ### hw/asr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module asr_sync #(
	parameter int W = 16
) (
	input  wire logic         clk_in,
	input  wire logic         sys_rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= d_in;
			s2_q <= s1_q;
		end
	end
	assign q_out = s2_q;
endmodule
`default_nettype wire

// ### hw/asr_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl
	import asr_pkg::*;
(
	input  wire logic                      clk_in,
	input  wire logic                      sys_rst_in,
	input  wire logic                      req_valid_in,
	input  wire logic                      req_write_in,
	input  wire logic [asr_pkg::ADDR_W-1:0] req_addr_in,
	input  wire logic [asr_pkg::DATA_W-1:0] req_wdata_in,
	input  wire logic [asr_pkg::LANES-1:0]  req_lanes_in,
	output logic                           req_ready_out,
	output logic                           rd_valid_out,
	output logic      [asr_pkg::DATA_W-1:0] rd_data_out,
	output logic      [asr_pkg::ADDR_W-1:0] mem_addr_out,
	output logic                           chip_sel_n_out,
	output logic                           out_en_n_out,
	output logic                           wr_strobe_n_out,
	output logic                           upper_lane_en_n_out,
	output logic                           lower_lane_en_n_out,
	output logic      [asr_pkg::DATA_W-1:0] mem_dq_out,
	output logic      [asr_pkg::DATA_W-1:0] mem_dq_oe_out,
	input  wire logic [asr_pkg::DATA_W-1:0] mem_dq_in
);
	import asr_pkg::*;

	typedef struct packed {
		asr_state_t          st;
		logic [CNT_W-1:0]    cnt;
		logic                ready;
		logic                rvalid;
		logic [DATA_W-1:0]   rdata;
		logic [ADDR_W-1:0]   addr;
		logic                cs_n;
		logic                oe_n;
		logic                we_n;
		logic [LANES-1:0]    lane_n;
		logic [DATA_W-1:0]   wdata;
		logic                drive;
		logic [DATA_W-1:0]   dq_oe;
	} asr_regs_t;

	asr_regs_t r_q;
	asr_regs_t r_d;
	logic [DATA_W-1:0] dq_sync;

	// pins are asynchronous to our clock; two flops before any use
	asr_sync #(
		.W(DATA_W)
	) u_sync (
		.clk_in    (clk_in),
		.sys_rst_in(sys_rst_in),
		.d_in      (mem_dq_in),
		.q_out     (dq_sync)
	);

	function automatic logic [CNT_W-1:0] asr_load(input int n);
		return CNT_W'(n - 1);
	endfunction

	function automatic logic [DATA_W-1:0] asr_lane_mask(input logic [LANES-1:0] lanes);
		return {{(DATA_W/2){lanes[1]}}, {(DATA_W/2){lanes[0]}}};
	endfunction

	always_comb begin
		r_d = r_q;
		r_d.rvalid = 1'b0;
		case (r_q.st)
			ASR_IDLE: begin
				r_d.ready = 1'b1;
				if (req_valid_in && r_q.ready && req_lanes_in != '0) begin
					r_d.ready = 1'b0;
					r_d.addr = req_addr_in;
					r_d.cs_n = 1'b0;
					r_d.lane_n = ~{req_lanes_in[1], req_lanes_in[0]};
					if (req_write_in) begin
						r_d.we_n = 1'b0;
						r_d.oe_n = 1'b1;
						r_d.wdata = req_wdata_in;
						r_d.drive = 1'b1;
						// only drive lanes being written; held past the strobes so data never races them
						r_d.dq_oe = asr_lane_mask(req_lanes_in);
						r_d.cnt = asr_load(WR_CYC);
						r_d.st = ASR_WR;
					end else begin
						r_d.we_n = 1'b1;
						r_d.oe_n = 1'b0;
						r_d.dq_oe = DATA_ZERO;
						// sync adds two cycles of latency on the data return
						r_d.cnt = asr_load(RD_CYC + 2);
						r_d.st = ASR_RD;
					end
				end
			end
			ASR_RD: begin
				if (r_q.cnt == CNT_ZERO) begin
					r_d.rdata = dq_sync;
					r_d.rvalid = 1'b1;
					r_d.cs_n = 1'b1;
					r_d.oe_n = 1'b1;
					r_d.lane_n = '1;
					r_d.cnt = asr_load(HZ_CYC); // memory needs time to float
					r_d.st = ASR_TURN;
				end else begin
					r_d.cnt = r_q.cnt - CNT_W'(1);
				end
			end
			ASR_WR: begin
				if (r_q.cnt == CNT_ZERO) begin
					// select and strobe rise together; data still driven
					r_d.we_n = 1'b1;
					r_d.cs_n = 1'b1;
					r_d.lane_n = '1;
					r_d.cnt = asr_load(WC_CYC - WR_CYC + 1);
					r_d.st = ASR_WHOLD;
				end else begin
					r_d.cnt = r_q.cnt - CNT_W'(1);
				end
			end
			ASR_WHOLD: begin
				// hold data one cycle past the ending edge
				r_d.drive = 1'b0;
				r_d.dq_oe = DATA_ZERO;
				r_d.st = ASR_TURN;
				r_d.cnt = r_q.cnt;
			end
			ASR_TURN: begin
				if (r_q.cnt == CNT_ZERO) begin
					r_d.ready = 1'b1;
					r_d.st = ASR_IDLE;
				end else begin
					r_d.cnt = r_q.cnt - CNT_W'(1);
				end
			end
			default: begin
				r_d.st = ASR_IDLE;
			end
		endcase
		if (sys_rst_in) begin
			r_d = '0;
			r_d.st = ASR_IDLE;
			r_d.cs_n = 1'b1;
			r_d.oe_n = 1'b1;
			r_d.we_n = 1'b1;
			r_d.lane_n = '1;
		end
	end

	always_ff @(posedge clk_in) begin
		r_q <= r_d;
	end

	assign req_ready_out       = r_q.ready;
	assign rd_valid_out        = r_q.rvalid;
	assign rd_data_out         = r_q.rdata;
	assign mem_addr_out        = r_q.addr;
	assign chip_sel_n_out      = r_q.cs_n;
	assign out_en_n_out        = r_q.oe_n;
	assign wr_strobe_n_out     = r_q.we_n;
	assign upper_lane_en_n_out = r_q.lane_n[1];
	assign lower_lane_en_n_out = r_q.lane_n[0];
	assign mem_dq_out          = r_q.wdata;
	// registered enable; never set while a read has the bus
	assign mem_dq_oe_out       = r_q.dq_oe;

	property p_read_we_high;
		@(posedge clk_in) disable iff (sys_rst_in)
		(!r_q.cs_n && !r_q.oe_n) |-> r_q.we_n;
	endproperty
	a_read_we_high: assert property (p_read_we_high) else $error("strobe low during read");

	property p_no_contend;
		@(posedge clk_in) disable iff (sys_rst_in)
		!r_q.oe_n |-> (mem_dq_oe_out == DATA_ZERO);
	endproperty
	a_no_contend: assert property (p_no_contend) else $error("bus driven while output enabled");

	property p_wr_width;
		@(posedge clk_in) disable iff (sys_rst_in)
		$fell(r_q.we_n) |-> (!r_q.we_n && !r_q.cs_n && (r_q.lane_n != '1)) [*1] ##1 (r_q.we_n && r_q.cs_n);
	endproperty
	a_wr_width: assert property (p_wr_width) else $error("write pulse too short");

	property p_data_hold;
		@(posedge clk_in) disable iff (sys_rst_in)
		($rose(r_q.we_n) && r_q.drive) |-> $stable(mem_dq_out) && $stable(mem_dq_oe_out) && r_q.drive;
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("write data not held");

	property p_end_together;
		@(posedge clk_in) disable iff (sys_rst_in)
		$rose(r_q.we_n) |-> $rose(r_q.cs_n) && r_q.oe_n;
	endproperty
	a_end_together: assert property (p_end_together) else $error("write end not clean");

	property p_addr_stable;
		@(posedge clk_in) disable iff (sys_rst_in)
		!r_q.cs_n && !$past(r_q.cs_n) |-> $stable(r_q.addr);
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("address moved while selected");

	property p_idle_float;
		@(posedge clk_in) disable iff (sys_rst_in)
		r_q.cs_n |-> r_q.oe_n && r_q.we_n;
	endproperty
	a_idle_float: assert property (p_idle_float) else $error("strobes active while deselected");

	property p_rd_done;
		@(posedge clk_in) disable iff (sys_rst_in)
		$fell(r_q.oe_n) |-> ##[1:12] r_q.rvalid;
	endproperty
	a_rd_done: assert property (p_rd_done) else $error("read never completed");
endmodule
`default_nettype wire

// ### bench/asr_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module asr_sram_model
	import asr_pkg::*;
(
	input  wire logic [asr_pkg::ADDR_W-1:0] addr_in,
	input  wire logic                       chip_sel_n_in,
	input  wire logic                       out_en_n_in,
	input  wire logic                       wr_strobe_n_in,
	input  wire logic                       upper_lane_en_n_in,
	input  wire logic                       lower_lane_en_n_in,
	input  wire logic [asr_pkg::DATA_W-1:0] dq_in,
	output logic      [asr_pkg::DATA_W-1:0] dq_out,
	output logic      [asr_pkg::DATA_W-1:0] drv_out
);
	import asr_pkg::*;
	logic [DATA_W-1:0] mem [0:65535];
	logic [DATA_W-1:0] mask, wd, wm, last;
	logic [ADDR_W-1:0] wa;
	logic              wr_act;
	assign mask = {{8{~upper_lane_en_n_in}}, {8{~lower_lane_en_n_in}}};
	assign wr_act = ~chip_sel_n_in & ~wr_strobe_n_in & (|mask);
	// capture up to the edge that ends the overlap, so data hold of zero is enough
	always_latch if (wr_act) begin
		wa = addr_in;
		wd = dq_in;
		wm = mask;
	end
	always @(negedge wr_act) mem[wa] = (mem[wa] & ~wm) | (wd & wm);
	// drives only when selected with oe low and strobe high
	assign drv_out = (~chip_sel_n_in & ~out_en_n_in & wr_strobe_n_in) ? mask : '0;
	always_latch if (|drv_out) last = mem[addr_in];
	// floating lanes show the inverse of the last read so stale data never passes
	assign dq_out = (mem[addr_in] & drv_out) | (~last & ~drv_out);
endmodule
`default_nettype wire

// ### bench/async_sram_x16_byte_lane_access_bench.sv
`timescale 1ns/1ps
`default_nettype none
module async_sram_x16_byte_lane_access_bench;
	import asr_pkg::*;
	typedef struct packed {logic w; logic [15:0] a; logic [15:0] d; logic [1:0] l;} asr_row_t;
	logic clk_in = 1'h0, sys_rst_in = 1'h1, req_valid_in = 1'h0, req_write_in = 1'h0;
	logic [15:0] req_addr_in = 16'h0000, req_wdata_in = 16'h0000;
	logic [1:0] req_lanes_in = 2'h0;
	logic ready, rdv, cs_n, oe_n, we_n, ub_n, lb_n;
	logic [15:0] rdata, addr, dq, dq_oe, mdq, drv, bus;
	int err_count = 0, comparisons = 0;
	asr_row_t rows [9] = '{'{1'h1, 16'h0000, 16'h1234, 2'h3}, '{1'h1, 16'hffff, 16'habcd, 2'h3},
		'{1'h1, 16'h0000, 16'h5678, 2'h1}, '{1'h1, 16'hffff, 16'h9900, 2'h2},
		'{1'h0, 16'h0000, 16'h1278, 2'h3}, '{1'h0, 16'hffff, 16'h99cd, 2'h3},
		'{1'h0, 16'h0000, 16'h1200, 2'h2}, '{1'h0, 16'hffff, 16'h00cd, 2'h1},
		'{1'h0, 16'h0000, 16'h0078, 2'h1}};
	assign bus = (dq_oe & dq) | (~dq_oe & mdq);
	asr_ctrl asr_ctrl_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
		.req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
		.req_lanes_in(req_lanes_in), .req_ready_out(ready), .rd_valid_out(rdv), .rd_data_out(rdata),
		.mem_addr_out(addr), .chip_sel_n_out(cs_n), .out_en_n_out(oe_n), .wr_strobe_n_out(we_n),
		.upper_lane_en_n_out(ub_n), .lower_lane_en_n_out(lb_n), .mem_dq_out(dq),
		.mem_dq_oe_out(dq_oe), .mem_dq_in(bus));
	asr_sram_model asr_sram_model_inst (.addr_in(addr), .chip_sel_n_in(cs_n), .out_en_n_in(oe_n),
		.wr_strobe_n_in(we_n), .upper_lane_en_n_in(ub_n), .lower_lane_en_n_in(lb_n), .dq_in(bus),
		.dq_out(mdq), .drv_out(drv));
	initial forever #10 clk_in = ~clk_in;
	task check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task req(input asr_row_t r);
		@(posedge clk_in);
		{req_valid_in, req_write_in, req_addr_in, req_wdata_in, req_lanes_in} <= {1'h1, r};
		do @(negedge clk_in); while (ready !== 1'h1);
		@(posedge clk_in);
		req_valid_in <= 1'h0;
		if (!r.w) begin
			repeat (20) begin
				@(negedge clk_in);
				if (rdv === 1'h1) break;
			end
			check({15'h0000, rdv}, 16'h0001);
			check(rdata & {{8{r.l[1]}}, {8{r.l[0]}}}, r.d);
		end
		$display("test done: op=%h addr=%h", r.w, r.a);
	endtask
	// both sides driving the bus at once
	always @(negedge clk_in) if (!sys_rst_in && (dq_oe & drv) != 16'h0000) check(dq_oe & drv, 16'h0000);
	initial begin
		repeat (3) @(posedge clk_in);
		sys_rst_in <= 1'h0;
		foreach (rows[i]) req(rows[i]);
		@(posedge clk_in);
		{req_valid_in, req_lanes_in} <= {1'h1, 2'h0};
		repeat (4) begin
			@(negedge clk_in);
			check({15'h0000, cs_n}, 16'h0001);
		end
		$display("test done: zero lanes");
		@(posedge clk_in);
		{req_valid_in, sys_rst_in} <= {1'h0, 1'h1};
		repeat (2) @(negedge clk_in);
		check({cs_n, oe_n, we_n, ub_n, lb_n, ready}, 16'h003e);
		check(dq_oe, 16'h0000);
		@(posedge clk_in);
		sys_rst_in <= 1'h0;
		$display("test done: reset");
		req(rows[4]);
		test_done();
	end
	initial begin
		#(2000 * CLK_PERIOD_NS);
		err_count++;
		test_done();
	end
endmodule
`default_nettype wire
